// ### design/snw_cmd.sv
`timescale 1ns/1ps
`include "snw_defs.svh"
// Serial instruction decoder for the write side of the flash.
// The serial pins are sampled on mclk_in, so the serial clock must run
// well below half the system clock rate.
module snw_cmd import snw_pkg::*; #(
  // Self-timed erase length in system clock cycles.
  parameter int ERASE_CYC = `SNW_ERASE_US * `SNW_CLK_MHZ
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Serial pins.
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic [3:0] io_in,
  output logic dout_out,
  output logic dout_oe_out,
  // Array side events.
  input wire logic ext_busy_in,
  input wire logic prog_done_in,
  input wire logic reset_done_in,
  input wire logic ecc_upd_in,
  input wire logic [1:0] ecc_res_in,
  input wire logic [15:0] fail_page_in,
  // Erase request.
  output logic erase_req_out,
  output logic [15:0] erase_page_out,
  // Page buffer write stream.
  output logic wr_valid_out,
  output snw_wr_t wr_data_out,
  input wire logic wr_ready_in,
  // Status and configuration bits.
  output logic wel_out,
  output logic busy_out,
  output snw_cfg_t cfg_out,
  output logic [1:0] ecc_result_out,
  output logic remap_table_full_out
);
  // Edge detection of the serial pins.
  logic sclk_q, cs_q;
  // Frame state.
  snw_state_t state, next_state;
  logic [7:0] op, next_op;
  logic [31:0] sh, next_sh;
  logic [5:0] cnt, next_cnt;
  logic [5:0] need, next_need;
  logic [2:0] bc, next_bc;
  logic [12:0] col, next_col;
  logic fill, next_fill;
  logic [9:0] oc, next_oc;
  logic [7:0] radr, next_radr;
  logic dout, next_dout, doe, next_doe;
  // Device state.
  logic write_enable_latch, next_wel;
  logic busy, next_busy;
  logic [19:0] ecnt, next_ecnt;
  snw_cfg_t cfg, next_cfg;
  logic [1:0] ecc, next_ecc;
  logic [15:0] fpage, next_fpage;
  logic ereq, next_ereq;
  logic [15:0] epage, next_epage;
  // Pending word waiting for buffer space.
  logic pv, next_pv;
  snw_wr_t pd, next_pd;
  logic pready;
  // Remap table hookup.
  logic add, next_add;
  logic [31:0] tword;
  logic full;

  logic rise, fall, cs_up;
  assign rise = sclk_in && !sclk_q && !cs_n_in;
  assign fall = !sclk_in && sclk_q && !cs_n_in;
  assign cs_up = cs_n_in && !cs_q;

  // True when the block of a page falls in the protected range.
  function automatic logic prot_hit(input logic [3:0] bp, input logic tb,
                                    input logic [15:0] page);
    logic [10:0] sz;
    logic [10:0] blk;
    blk = {1'b0, page[15:6]};
    sz = 11'd1 << (bp - 4'd1);
    if (bp == 4'h0) begin
      prot_hit = 1'b0;
    end else if (bp > 4'ha) begin
      prot_hit = 1'b1;
    end else if (tb) begin
      prot_hit = (blk < sz);
    end else begin
      prot_hit = (blk >= (11'd1024 - sz));
    end
  endfunction

  // Readback byte of a status register address.
  function automatic logic [7:0] stat_byte(input logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    case (a[7:4])
      `SNW_RA_PROT: begin
        b[`SNW_PR_SRP0] = cfg.srp[0];
        b[`SNW_PR_BP_HI:`SNW_PR_BP_LO] = cfg.bp;
        b[`SNW_PR_TB] = cfg.tb;
        b[`SNW_PR_WPE] = cfg.wpe;
        b[`SNW_PR_SRP1] = cfg.srp[1];
      end
      `SNW_RA_CONF: begin
        b[`SNW_CR_OTPL] = cfg.otpl;
        b[`SNW_CR_OTPE] = cfg.otpe;
        b[`SNW_CR_SR1L] = cfg.sr1l;
        b[`SNW_CR_ECCE] = cfg.ecce;
        b[`SNW_CR_BUF] = cfg.bufsel;
      end
      `SNW_RA_STAT: begin
        b[`SNW_SR_FULL] = full;
        b[`SNW_SR_ECC_HI] = ecc[1];
        b[`SNW_SR_ECC_LO] = ecc[0];
        b[`SNW_SR_WEL] = write_enable_latch;
        b[`SNW_SR_BUSY] = busy;
      end
      default: b = 8'h00;
    endcase
    stat_byte = b;
  endfunction

  // Next state of the whole instruction sequencer.
  always_comb begin
    logic ok;
    logic [5:0] nd;
    logic [7:0] b;
    logic [7:0] sb;
    ok = 1'b0;
    nd = `SNW_ARG_DUMMY;
    b = {sh[6:0], io_in[0]};
    sb = stat_byte(radr);
    next_state = state;
    next_op = op;
    next_sh = sh;
    next_cnt = cnt;
    next_need = need;
    next_bc = bc;
    next_col = col;
    next_fill = fill;
    next_oc = oc;
    next_radr = radr;
    next_dout = dout;
    next_doe = doe;
    next_wel = write_enable_latch;
    next_ecnt = ecnt;
    next_cfg = cfg;
    next_ecc = ecc;
    next_fpage = fpage;
    next_ereq = 1'b0;
    next_epage = epage;
    next_pv = pv;
    next_pd = pd;
    next_add = 1'b0;
    if (ecnt != 20'd0) begin
      next_ecnt = ecnt - 20'd1;
      if (ecnt == 20'd1) begin
        next_wel = 1'b0;
      end
    end
    if (prog_done_in || reset_done_in) begin
      next_wel = 1'b0;
    end
    if (ecc_upd_in) begin
      next_ecc = ecc_res_in;
      if (ecc_res_in[1]) begin
        next_fpage = fail_page_in;
      end
    end
    if (pv && pready) begin
      next_pv = 1'b0;
    end
    // Deselect ends every frame and releases the output.
    if (cs_n_in) begin
      next_state = ST_OP;
      next_cnt = 6'd0;
      next_doe = 1'b0;
    end
    if (cs_up && state == ST_HOLD) begin
      if (!prot_hit(cfg.bp, cfg.tb, epage)) begin
        next_ereq = 1'b1;
        next_ecnt = 20'(ERASE_CYC);
      end else begin
        next_wel = 1'b0;
      end
    end else if (rise) begin
      case (state)
        ST_OP: begin
          next_sh = {sh[30:0], io_in[0]};
          next_cnt = cnt + 6'd1;
          if (cnt == 6'd7) begin
            next_op = b;
            next_cnt = 6'd0;
            case (b)
              `SNW_OP_WREN: next_wel = 1'b1;
              `SNW_OP_WRDI: next_wel = 1'b0;
              `SNW_OP_SRW1, `SNW_OP_SRW2: begin
                ok = write_enable_latch && !busy;
                nd = `SNW_ARG_STS;
              end
              `SNW_OP_LINK: begin
                ok = !busy;
                nd = `SNW_ARG_LINK;
              end
              `SNW_OP_SRR1, `SNW_OP_SRR2, `SNW_OP_TBL, `SNW_OP_FAIL: ok = 1'b1;
              `SNW_OP_ERASE, `SNW_OP_LOAD, `SNW_OP_RLOAD: begin
                ok = write_enable_latch && !busy;
                nd = `SNW_ARG_ADDR;
              end
              `SNW_OP_QLOAD, `SNW_OP_QRLOAD: begin
                ok = write_enable_latch && !busy && !cfg.wpe;
                nd = `SNW_ARG_ADDR;
              end
              default: ok = 1'b0;
            endcase
            next_need = nd;
            next_state = ok ? ST_ARG : ST_IGN;
          end
        end
        ST_ARG: begin
          next_sh = {sh[30:0], io_in[0]};
          next_cnt = cnt + 6'd1;
          if (cnt == need - 6'd1) begin
            next_cnt = 6'd0;
            next_state = ST_IGN;
            case (op)
              `SNW_OP_SRW1, `SNW_OP_SRW2: begin
                if (next_sh[15:12] == `SNW_RA_PROT) begin
                  next_cfg.srp = {next_sh[`SNW_PR_SRP1], next_sh[`SNW_PR_SRP0]};
                  next_cfg.bp = next_sh[`SNW_PR_BP_HI:`SNW_PR_BP_LO];
                  next_cfg.tb = next_sh[`SNW_PR_TB];
                  next_cfg.wpe = next_sh[`SNW_PR_WPE];
                end else if (next_sh[15:12] == `SNW_RA_CONF) begin
                  next_cfg.otpl = next_sh[`SNW_CR_OTPL];
                  next_cfg.otpe = next_sh[`SNW_CR_OTPE];
                  next_cfg.sr1l = next_sh[`SNW_CR_SR1L];
                  next_cfg.ecce = next_sh[`SNW_CR_ECCE];
                  next_cfg.bufsel = next_sh[`SNW_CR_BUF];
                end
                next_wel = 1'b0;
              end
              `SNW_OP_LINK: next_add = !full;
              `SNW_OP_ERASE: begin
                next_epage = next_sh[15:0];
                next_state = ST_HOLD;
              end
              `SNW_OP_LOAD, `SNW_OP_RLOAD, `SNW_OP_QLOAD, `SNW_OP_QRLOAD: begin
                next_col = {1'b0, next_sh[19:8]};
                next_fill = (op == `SNW_OP_LOAD) || (op == `SNW_OP_QLOAD);
                next_bc = 3'd0;
                next_state = ST_LOAD;
              end
              default: begin
                next_radr = next_sh[7:0];
                next_oc = 10'd0;
                next_state = ST_OUT;
              end
            endcase
          end
        end
        ST_LOAD: begin
          next_bc = bc + 3'd1;
          if (op == `SNW_OP_QLOAD || op == `SNW_OP_QRLOAD) begin
            next_sh = {sh[27:0], io_in};
          end else begin
            next_sh = {sh[30:0], io_in[0]};
          end
          if (next_bc[0] == 1'b0 && (bc == 3'd7 ||
              ((op == `SNW_OP_QLOAD || op == `SNW_OP_QRLOAD) && bc == 3'd1))) begin
            next_bc = 3'd0;
            if (col < `SNW_BUF_BYTES && !next_pv) begin
              next_pv = 1'b1;
              next_pd = '{fill_ff: fill, col: col[11:0], data: next_sh[7:0]};
              next_fill = 1'b0;
            end
            if (col != 13'h1fff) begin
              next_col = col + 13'd1;
            end
          end
        end
        ST_HOLD: next_state = ST_IGN;
        default: next_state = state;
      endcase
    end
    // Output bits change on the falling serial edge.
    if (fall && state == ST_OUT) begin
      next_doe = 1'b1;
      next_oc = oc + 10'd1;
      case (op)
        `SNW_OP_TBL: next_dout = tword[~oc[4:0]];
        `SNW_OP_FAIL: next_dout = (oc < 10'd16) ? fpage[~oc[3:0]] : 1'b0;
        default: next_dout = sb[~oc[2:0]];
      endcase
    end
    next_busy = (next_ecnt != 20'd0) || ext_busy_in;
  end

  // Sequencer registers.
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      state <= ST_OP;
      op <= 8'h00;
      sh <= 32'h0;
      cnt <= 6'd0;
      need <= 6'd0;
      bc <= 3'd0;
      col <= 13'h0;
      fill <= 1'b0;
      oc <= 10'h0;
      radr <= 8'h00;
      dout <= 1'b0;
      doe <= 1'b0;
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
      ecnt <= 20'h0;
      cfg <= `SNW_CFG_RST;
      ecc <= 2'h0;
      fpage <= 16'h0;
      ereq <= 1'b0;
      epage <= 16'h0;
      pv <= 1'b0;
      pd <= '0;
      add <= 1'b0;
    end else begin
      sclk_q <= sclk_in;
      cs_q <= cs_n_in;
      state <= next_state;
      op <= next_op;
      sh <= next_sh;
      cnt <= next_cnt;
      need <= next_need;
      bc <= next_bc;
      col <= next_col;
      fill <= next_fill;
      oc <= next_oc;
      radr <= next_radr;
      dout <= next_dout;
      doe <= next_doe;
      write_enable_latch <= next_wel;
      busy <= next_busy;
      ecnt <= next_ecnt;
      cfg <= next_cfg;
      ecc <= next_ecc;
      fpage <= next_fpage;
      ereq <= next_ereq;
      epage <= next_epage;
      pv <= next_pv;
      pd <= next_pd;
      add <= next_add;
    end
  end

  // Stalls reach the pending word, so a full buffer holds it.
  snw_buf2 snw_buf2_inst (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(pv),
    .in_data_in(pd),
    .in_ready_out(pready),
    .out_valid_out(wr_valid_out),
    .out_data_out(wr_data_out),
    .out_ready_in(wr_ready_in)
  );

  snw_remap snw_remap_inst (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .add_in(add),
    .lba_in(sh[31:16]),
    .pba_in(sh[15:0]),
    .idx_in(oc[9:5]),
    .word_out(tword),
    .full_out(full)
  );

  assign dout_out = dout;
  assign dout_oe_out = doe;
  assign erase_req_out = ereq;
  assign erase_page_out = epage;
  assign wel_out = write_enable_latch;
  assign busy_out = busy;
  assign cfg_out = cfg;
  assign ecc_result_out = ecc;
  assign remap_table_full_out = full;
endmodule

// ### design/snw_defs.svh
`ifndef SNW_DEFS_SVH
`define SNW_DEFS_SVH
// Overview of operation
// - Status write: opcode, register address, data byte.
// - Only protect and configuration bits are writable.
// - Status write needs write enable latch set.
// - Power-up: protect level, top-bottom, ECC enable set.
// - Opcode 06h sets write enable latch.
// - Opcode 04h clears write enable latch.
// - Latch clears at power-up and write completions.
// - Remap link: A1h, logical then physical address.
// - Twenty links at most, then table full.
// - A5h streams links after eight dummy clocks.
// - Logical address top bits encode link state.
// - ECC enable chooses computed or loaded spare bytes.
// - Reads update ECC result, high bit means uncorrectable.
// - A9h returns last uncorrectable page address.
// - D8h erases a 64-page block under latch.
// - Extra clocks after erase address discard it.
// - Busy held for erase time, then latch cleared.
// - Protected blocks are never erased.
// - Load: opcode, column, dummy, bytes up to 2112.
// - 02h fills unwritten bytes, 84h keeps them.
// - Four-line loads, disabled by write protect enable.
// - Status reads allowed at any time.

// Opcodes.
`define SNW_OP_WREN 8'h06
`define SNW_OP_WRDI 8'h04
`define SNW_OP_SRW1 8'h1f
`define SNW_OP_SRW2 8'h01
`define SNW_OP_SRR1 8'h0f
`define SNW_OP_SRR2 8'h05
`define SNW_OP_LINK 8'ha1
`define SNW_OP_TBL 8'ha5
`define SNW_OP_FAIL 8'ha9
`define SNW_OP_ERASE 8'hd8
`define SNW_OP_LOAD 8'h02
`define SNW_OP_RLOAD 8'h84
`define SNW_OP_QLOAD 8'h32
`define SNW_OP_QRLOAD 8'h34

// Register address high nibbles.
`define SNW_RA_PROT 4'ha
`define SNW_RA_CONF 4'hb
`define SNW_RA_STAT 4'hc

// Protect register field positions.
`define SNW_PR_SRP0 7
`define SNW_PR_BP_HI 6
`define SNW_PR_BP_LO 3
`define SNW_PR_TB 2
`define SNW_PR_WPE 1
`define SNW_PR_SRP1 0
// Configuration register field positions.
`define SNW_CR_OTPL 7
`define SNW_CR_OTPE 6
`define SNW_CR_SR1L 5
`define SNW_CR_ECCE 4
`define SNW_CR_BUF 3
// Status register field positions.
`define SNW_SR_FULL 6
`define SNW_SR_ECC_HI 5
`define SNW_SR_ECC_LO 4
`define SNW_SR_WEL 1
`define SNW_SR_BUSY 0

// Reset value of the writable bits, in snw_cfg_t order.
`define SNW_CFG_RST 13'h07c2

// Sizes and counts.
`define SNW_LINKS 20
`define SNW_BUF_BYTES 13'd2112
`define SNW_ARG_STS 6'd16
`define SNW_ARG_LINK 6'd32
`define SNW_ARG_DUMMY 6'd8
`define SNW_ARG_ADDR 6'd24
`define SNW_CLK_MHZ 20
`define SNW_ERASE_US 2000
`endif

// ### design/snw_pkg.sv
package snw_pkg;
  // Frame sequencer states.
  typedef enum logic [2:0] {
    ST_OP, ST_ARG, ST_LOAD, ST_OUT, ST_HOLD, ST_IGN
  } snw_state_t;

  // One word on its way to the page buffer.
  typedef struct packed {
    logic fill_ff;
    logic [11:0] col;
    logic [7:0] data;
  } snw_wr_t;

  // Writable protect and configuration bits.
  typedef struct packed {
    logic [1:0] srp;
    logic tb;
    logic [3:0] bp;
    logic wpe;
    logic otpl;
    logic otpe;
    logic sr1l;
    logic ecce;
    logic bufsel;
  } snw_cfg_t;
endpackage

// ### design/snw_buf2.sv
`timescale 1ns/1ps
// Two-entry buffer that lets the page buffer stall without losing a word.
module snw_buf2 import snw_pkg::*; (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Filling side.
  input wire logic in_valid_in,
  input wire snw_wr_t in_data_in,
  output logic in_ready_out,
  // Draining side.
  output logic out_valid_out,
  output snw_wr_t out_data_out,
  input wire logic out_ready_in
);
  snw_wr_t mem [0:1];
  snw_wr_t next_mem [0:1];
  logic wp, rp, next_wp, next_rp;
  logic [1:0] cnt, next_cnt;
  logic vld, next_vld;

  // Pointer and count update; push and pop may meet in one cycle.
  always_comb begin
    logic push;
    logic pop;
    push = in_valid_in && (cnt != 2'd2);
    pop = vld && out_ready_in;
    next_mem = mem;
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (push) begin
      next_mem[wp] = in_data_in;
      next_wp = ~wp;
    end
    if (pop) begin
      next_rp = ~rp;
    end
    next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    next_vld = (next_cnt != 2'd0);
  end

  // State registers.
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'd0;
      vld <= 1'b0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      vld <= next_vld;
      mem <= next_mem;
    end
  end

  assign in_ready_out = (cnt != 2'd2);
  assign out_valid_out = vld;
  assign out_data_out = mem[rp];
endmodule

// ### design/snw_remap.sv
`timescale 1ns/1ps
`include "snw_defs.svh"
// Remap table of logical to physical block links.
// The table is held in flops and clears at reset; a real part keeps it.
module snw_remap import snw_pkg::*; (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Link add request, one-cycle pulse.
  input wire logic add_in,
  input wire logic [15:0] lba_in,
  input wire logic [15:0] pba_in,
  // Read port.
  input wire logic [4:0] idx_in,
  output logic [31:0] word_out,
  output logic full_out
);
  logic [31:0] tbl [0:`SNW_LINKS-1];
  logic [31:0] next_tbl [0:`SNW_LINKS-1];
  logic [4:0] used, next_used;
  logic full, next_full;

  // Append a link while free entries remain.
  always_comb begin
    next_tbl = tbl;
    next_used = used;
    if (add_in && !full) begin
      next_tbl[used] = {2'b10, lba_in[13:0], pba_in};
      next_used = used + 5'd1;
    end
    next_full = (next_used == 5'(`SNW_LINKS));
  end

  // Table registers; free entries read back as zero.
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      used <= 5'd0;
      full <= 1'b0;
      for (int i = 0; i < `SNW_LINKS; i++) begin
        tbl[i] <= 32'h0;
      end
    end else begin
      used <= next_used;
      full <= next_full;
      tbl <= next_tbl;
    end
  end

  assign word_out = (idx_in < 5'(`SNW_LINKS)) ? tbl[idx_in] : 32'h0;
  assign full_out = full;
endmodule

// ### dv/snw_cmd_monitor.sv
`timescale 1ns/1ps
// Port checker for the write-side decoder; one clock domain throughout.
module snw_cmd_monitor import snw_pkg::*; #(
  // Must match the erase length of the watched decoder.
  parameter int ERASE_CYC = 50
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Watched inputs.
  input wire logic cs_n_in,
  input wire logic ext_busy_in,
  input wire logic wr_ready_in,
  // Watched outputs.
  input wire logic dout_oe_out,
  input wire logic erase_req_out,
  input wire logic wr_valid_out,
  input wire snw_wr_t wr_data_out,
  input wire logic wel_out,
  input wire logic busy_out,
  input wire snw_cfg_t cfg_out,
  input wire logic remap_table_full_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // Busy run length; a timer that never expires shows up here.
  int busy_run;
  // Counts consecutive busy cycles, cleared by reset.
  always_ff @(posedge mclk_in) begin
    busy_run <= (!reset_n_in || !busy_out) ? 0 : busy_run + 1;
  end
  // An erase request is one pulse followed by busy.
  sequence s_erase_go;
    erase_req_out ##1 (busy_out && !erase_req_out);
  endsequence
  a_erase_starts: assert property (erase_req_out |-> wel_out ##0 s_erase_go)
    else $error("erase request without latch or busy");
  a_busy_bounded: assert property (busy_run <= ERASE_CYC + 2)
    else $error("busy held past erase time");
  a_erase_idle: assert property (erase_req_out |-> !$past(busy_out))
    else $error("erase started while busy");
  a_ext_busy: assert property (ext_busy_in |=> busy_out)
    else $error("array busy not reflected");
  a_oe_release: assert property (cs_n_in [*3] |-> !dout_oe_out)
    else $error("data out driven outside a frame");
  a_cfg_latch: assert property (!$stable(cfg_out) |-> $past(wel_out))
    else $error("settings changed without latch");
  a_wel_framed: assert property ($rose(wel_out) |-> !$past(cs_n_in))
    else $error("latch set outside a frame");
  a_full_sticky: assert property (remap_table_full_out |=> remap_table_full_out)
    else $error("table full flag dropped");
  a_word_holds: assert property (wr_valid_out && !wr_ready_in |=>
    wr_valid_out && $stable(wr_data_out))
    else $error("stalled word lost or changed");
endmodule

bind snw_cmd snw_cmd_monitor #(.ERASE_CYC(ERASE_CYC)) snw_cmd_monitor_inst (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
  .ext_busy_in(ext_busy_in), .wr_ready_in(wr_ready_in), .dout_oe_out(dout_oe_out),
  .erase_req_out(erase_req_out), .wr_valid_out(wr_valid_out), .wr_data_out(wr_data_out),
  .wel_out(wel_out), .busy_out(busy_out), .cfg_out(cfg_out),
  .remap_table_full_out(remap_table_full_out));

// ### dv/snw_host.sv
`timescale 1ns/1ps
// Host side of the serial link: drives select, clock and data lines.
module snw_host (
  // Clock.
  input wire logic mclk_in,
  // Serial data from the device.
  input wire logic dout_in,
  // Serial pins toward the device.
  output logic cs_n_out,
  output logic sclk_out,
  output logic [3:0] io_out
);
  // Select idles high and the clock idles low between frames.
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_out = 4'h0;
  end
  // rising edge shift
  // One clock: data set while low, answer read just before the rise.
  task automatic tick(input logic [3:0] d, output logic q);
    @(posedge mclk_in);
    cs_n_out <= 1'b0;
    sclk_out <= 1'b0;
    io_out <= d;
    repeat (3) @(posedge mclk_in);
    q = dout_in;
    sclk_out <= 1'b1;
    repeat (2) @(posedge mclk_in);
  endtask
  // Shifts n bits out MSB first and collects what came back.
  task automatic send(input logic [47:0] v, input int n, output logic [47:0] r);
    logic q;
    r = 48'h0;
    for (int i = n - 1; i >= 0; i--) begin
      tick({3'h0, v[i]}, q);
      r = {r[46:0], q};
    end
  endtask
  // select raised
  // Ends the frame; released data lines flip so a stale level is never trusted.
  task automatic done;
    @(posedge mclk_in);
    sclk_out <= 1'b0;
    repeat (2) @(posedge mclk_in);
    cs_n_out <= 1'b1;
    io_out <= ~io_out;
    repeat (3) @(posedge mclk_in);
  endtask
endmodule

// ### dv/snw_cmd_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the write-side instruction decoder.
module snw_cmd_tb import snw_pkg::*;;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cs_n, sclk, dout, dout_oe, erase_req, wr_valid, write_enable_latch, busy, full, q1;
  logic ext_busy = 1'b0, ecc_upd = 1'b0, wr_ready = 1'b1, zero = 1'b0;
  logic [3:0] io;
  logic [1:0] ecc_res = 2'h0, ecc_result;
  logic [15:0] fail_page = 16'h0, erase_page, er_page, k;
  logic [47:0] r;
  snw_wr_t wr_data;
  snw_cfg_t cfg;
  snw_wr_t wq[$];
  int fails = 0, n_tests = 0, n_er = 0, i;
  // Free-running 20 MHz clock.
  always #25 mclk_in = ~mclk_in;
  snw_host snw_host_inst (.mclk_in(mclk_in), .dout_in(dout), .cs_n_out(cs_n),
    .sclk_out(sclk), .io_out(io));
  // Short erase time keeps the run brief.
  snw_cmd #(.ERASE_CYC(300)) snw_cmd_inst (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .cs_n_in(cs_n), .sclk_in(sclk), .io_in(io), .dout_out(dout), .dout_oe_out(dout_oe),
    .ext_busy_in(ext_busy), .prog_done_in(zero), .reset_done_in(zero),
    .ecc_upd_in(ecc_upd), .ecc_res_in(ecc_res), .fail_page_in(fail_page),
    .erase_req_out(erase_req), .erase_page_out(erase_page), .wr_valid_out(wr_valid),
    .wr_data_out(wr_data), .wr_ready_in(wr_ready), .wel_out(write_enable_latch), .busy_out(busy),
    .cfg_out(cfg), .ecc_result_out(ecc_result), .remap_table_full_out(full));
  // Logs erase pulses and every accepted buffer word.
  always @(posedge mclk_in) begin
    if (erase_req === 1'b1) begin
      n_er++;
      er_page = erase_page;
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back(wr_data);
  end
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One whole frame: opcode, then n bits of argument.
  task automatic fr(input logic [7:0] op, input logic [47:0] a, input int n);
    snw_host_inst.send({40'h0, op}, 8, r);
    if (n > 0) snw_host_inst.send(a, n, r);
    snw_host_inst.done();
  endtask
  // Four-line load of one byte A5 at column 010.
  task automatic qld(input logic [7:0] op);
    snw_host_inst.send({40'h0, op}, 8, r);
    snw_host_inst.send(48'h001000, 24, r);
    snw_host_inst.tick(4'ha, q1);
    snw_host_inst.tick(4'h5, q1);
    snw_host_inst.done();
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk(cfg, 13'h07c2);
    chk(write_enable_latch, 1'b0);
    fr(8'h1f, 48'ha000, 16);
    chk(cfg, 13'h07c2);
    fr(8'h06, 48'h0, 0);
    chk(write_enable_latch, 1'b1);
    fr(8'h04, 48'h0, 0);
    chk(write_enable_latch, 1'b0);
    fr(8'h06, 48'h0, 0);
    fr(8'h01, 48'ha002, 16);
    chk(cfg, 13'h0022);
    chk(write_enable_latch, 1'b0);
    fr(8'h06, 48'h0, 0);
    qld(8'h32);
    chk(wq.size(), 0);
    fr(8'h1f, 48'ha000, 16);
    fr(8'h06, 48'h0, 0);
    fr(8'h1f, 48'hb01f, 16);
    chk(cfg, 13'h0003);
    $display("test settings done");
    fr(8'h06, 48'h0, 0);
    qld(8'h34);
    chk(wq[0], {1'b0, 12'h010, 8'ha5});
    // Receiver stalls while two bytes arrive; both must survive.
    wr_ready <= 1'b0;
    fr(8'h06, 48'h0, 0);
    fr(8'h84, 48'h0007_0011_22, 40);
    chk(wr_valid, 1'b1);
    wr_ready <= 1'b1;
    repeat (6) @(posedge mclk_in);
    chk(wq[1], {1'b0, 12'h007, 8'h11});
    chk(wq[2], {1'b0, 12'h008, 8'h22});
    fr(8'h06, 48'h0, 0);
    fr(8'h02, 48'h0005_00a5, 32);
    fr(8'h06, 48'h0, 0);
    fr(8'h84, 48'h0840_005a, 32);
    chk(wq[3], {1'b1, 12'h005, 8'ha5});
    chk(wq.size(), 4);
    fr(8'h06, 48'h0, 0);
    qld(8'h32);
    chk(wq[4], {1'b1, 12'h010, 8'ha5});
    $display("test loads done");
    fr(8'h06, 48'h0, 0);
    fr(8'hd8, 48'h40, 24);
    chk(n_er, 1);
    chk(er_page, 16'h0040);
    fr(8'h0f, 48'hc000, 16);
    chk(r[7:0], 8'h03);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk_in);
    if (busy !== 1'b0) begin
      fails++;
      $display("[ERR] %0t busy never cleared", $time);
      close_out();
    end
    chk(write_enable_latch, 1'b0);
    fr(8'hd8, 48'h40, 24);
    fr(8'h06, 48'h0, 0);
    fr(8'hd8, 48'h80, 25);
    chk(n_er, 1);
    ext_busy <= 1'b1;
    fr(8'h06, 48'h0, 0);
    fr(8'hd8, 48'h40, 24);
    chk(busy, 1'b1);
    ext_busy <= 1'b0;
    chk(n_er, 1);
    // Bottom block protected; an erase there must not start.
    fr(8'h06, 48'h0, 0);
    fr(8'h1f, 48'ha00c, 16);
    fr(8'h06, 48'h0, 0);
    fr(8'hd8, 48'h10, 24);
    chk(n_er, 1);
    chk(write_enable_latch, 1'b0);
    fr(8'h05, 48'hb000, 16);
    chk(r[7:0], 8'h18);
    $display("test erase done");
    ecc_upd <= 1'b1;
    ecc_res <= 2'h3;
    fail_page <= 16'h1234;
    @(posedge mclk_in);
    ecc_upd <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk(ecc_result, 2'h3);
    fr(8'ha9, 48'h0, 24);
    chk(r[15:0], 16'h1234);
    for (k = 0; k < 20; k++) begin
      chk(full, 1'b0);
      fr(8'ha1, {16'h0, 16'h0100 + k, 16'h0200 + k}, 32);
    end
    chk(full, 1'b1);
    fr(8'ha1, 48'h0300_0400, 32);
    fr(8'ha5, 48'h0, 40);
    chk(r[31:0], 32'h8100_0200);
    $display("test remap done");
    close_out();
  end
endmodule
